// >>> hdl/operating_mode_system_control.sv
/*
 Operating mode decoder with mode monitor and system control registers on AXI4-Lite.
 Assumes straps are asynchronous pins, porRst_n is the power-on reset and rst_n covers every reset.
*/
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "opmode_defines.svh"

module operating_mode_system_control (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        porRst_n,
	input  wire logic        mode_strap_2,
	input  wire logic        mode_strap_1,
	input  wire logic        mode_strap_0,
	input  wire logic        manual_reset_n,
	input  wire logic [3:0]  addr_output_enable_bits,
	input  wire logic [15:0] sharedDdr,
	input  wire logic [7:0]  lowDdr,
	input  wire logic        anyArea16,
	input  wire logic        allArea8,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             modeValid,
	output logic [1:0]       opMode,
	output logic             advancedMode,
	output logic             romEnable,
	output logic             extBusEnable,
	output logic             bus16,
	output logic [15:0]      sharedAddrOut,
	output logic [15:0]      sharedPortOut,
	output logic [7:0]       lowAddrOut,
	output logic [7:0]       lowPortOut,
	output logic [1:0]       irqCtrlMode,
	output logic             nonmask_irq_edge_sel,
	output logic             manualResetReq,
	output logic             onchip_ram_en
);
	logic [2:0]  strapMeta;
	logic [2:0]  strapSync;
	logic [1:0]  mresMeta;
	logic [1:0]  mresSync;
	logic [2:0]  mode_seen;
	logic [7:0]  system_control_reg;
	logic        awHeld;
	logic        wHeld;
	logic [11:0] awAddr;
	logic [31:0] wData;
	logic [3:0]  wStrb;
	opmode_pkg::wr_state_type wrState;
	opmode_pkg::op_mode_type  modeDec;
	logic        doWrite;
	logic [15:0] upperEnable;
	logic [7:0]  rdByte;
	logic        rdHit;
	logic        busMode16;

	// Straps and the manual reset pin are asynchronous
	always_ff @(posedge clk) begin
		strapMeta <= {mode_strap_2, mode_strap_1, mode_strap_0};
		strapSync <= strapMeta;
		mresMeta  <= {mresMeta[0], manual_reset_n};
		mresSync  <= {mresSync[0], mresMeta[1]};
	end

	always_comb begin
		modeValid = strapSync[2];
		modeDec   = opmode_pkg::op_mode_type'(strapSync[1:0]);
	end

	assign opMode       = strapSync[1:0];
	assign advancedMode = 1'b1;
	// Straps assumed frozen; no relatch logic beyond the synchroniser
	assign romEnable    = modeValid && strapSync[1];
	assign extBusEnable = modeValid && (modeDec != opmode_pkg::MODE_SINGLE_CHIP);

	always_comb begin
		busMode16 = 1'b0;
		case (modeDec)
			opmode_pkg::MODE_EXT_ROMOFF_16: busMode16 = !allArea8;
			opmode_pkg::MODE_EXT_ROMOFF_8:  busMode16 = anyArea16;
			opmode_pkg::MODE_EXT_ROMON_8:   busMode16 = anyArea16;
			default:                        busMode16 = 1'b0;
		endcase
	end

	// Upper 16 address pins: bits 15:13 carry A23-A21 on the top port-1 pins,
	// bit 12 is A20, bits 11:0 are A19-A8. Each enable bit covers a nibble.
	always_comb begin
		upperEnable = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			upperEnable[i] = addr_output_enable_bits[i / 4];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bus16         <= 1'b0;
			sharedAddrOut <= 16'h0000;
			sharedPortOut <= 16'h0000;
			lowAddrOut    <= 8'h00;
			lowPortOut    <= 8'h00;
		end else begin
			bus16 <= extBusEnable && busMode16;
			if (!extBusEnable) begin
				sharedAddrOut <= 16'h0000;
				lowAddrOut    <= 8'h00;
				lowPortOut    <= lowDdr;
			end else if (modeDec == opmode_pkg::MODE_EXT_ROMON_8) begin
				sharedAddrOut <= upperEnable;
				lowAddrOut    <= lowDdr;
				lowPortOut    <= 8'h00;
			end else begin
				sharedAddrOut <= upperEnable;
				lowAddrOut    <= 8'hFF;
				lowPortOut    <= 8'h00;
			end
			sharedPortOut <= extBusEnable ? (sharedDdr & ~upperEnable) : sharedDdr;
		end
	end

	// AXI write path: address and data taken in either order
	assign s_axi_awready = !awHeld && (wrState == opmode_pkg::WR_IDLE);
	assign s_axi_wready  = !wHeld && (wrState == opmode_pkg::WR_IDLE);
	assign doWrite       = awHeld && wHeld && (wrState == opmode_pkg::WR_IDLE);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awHeld       <= 1'b0;
			wHeld        <= 1'b0;
			awAddr       <= 12'h000;
			wData        <= 32'h0000_0000;
			wStrb        <= 4'h0;
			wrState      <= opmode_pkg::WR_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AXI_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			case (wrState)
				opmode_pkg::WR_IDLE: begin
					if (doWrite) begin
						awHeld       <= 1'b0;
						wHeld        <= 1'b0;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= ({awAddr[11:2], 2'b00} == `SYSTEM_CONTROL_OFFSET ||
							{awAddr[11:2], 2'b00} == `MODE_MONITOR_OFFSET) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
						wrState      <= opmode_pkg::WR_RESP;
					end
				end
				opmode_pkg::WR_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						wrState      <= opmode_pkg::WR_IDLE;
					end
				end
				default: wrState <= opmode_pkg::WR_IDLE;
			endcase
		end
	end

	// System control register; reserved bits 6 and 1 stay 0
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			system_control_reg <= `SYSCTL_RESET;
		end else if (doWrite && wStrb[0] && {awAddr[11:2], 2'b00} == `SYSTEM_CONTROL_OFFSET) begin
			system_control_reg <= wData[7:0] & `SYSCTL_WMASK;
		end
	end

	assign irqCtrlMode          = system_control_reg[`SYSCTL_BIT_IRQMODE_HI:`SYSCTL_BIT_IRQMODE_LO];
	assign nonmask_irq_edge_sel = system_control_reg[`SYSCTL_BIT_NMIEDGE];
	assign manualResetReq       = system_control_reg[`SYSCTL_BIT_MRESEN] && !mresSync[1];
	assign onchip_ram_en        = system_control_reg[`SYSCTL_BIT_RAMEN];

	// AXI read path; straps latched into the monitor at the read
	assign s_axi_arready = !s_axi_rvalid;
	assign rdHit = ({s_axi_araddr[11:2], 2'b00} == `MODE_MONITOR_OFFSET) ||
		({s_axi_araddr[11:2], 2'b00} == `SYSTEM_CONTROL_OFFSET);

	always_comb begin
		rdByte = 8'h00;
		if ({s_axi_araddr[11:2], 2'b00} == `MODE_MONITOR_OFFSET) begin
			rdByte = {5'h00, strapSync};
		end else if ({s_axi_araddr[11:2], 2'b00} == `SYSTEM_CONTROL_OFFSET) begin
			rdByte = system_control_reg;
		end
	end

	// Only power-on reset clears the latch; a manual reset keeps it
	always_ff @(posedge clk) begin
		if (!porRst_n) begin
			mode_seen <= `MODE_SEEN_RESET;
		end else if (s_axi_arvalid && s_axi_arready &&
			{s_axi_araddr[11:2], 2'b00} == `MODE_MONITOR_OFFSET) begin
			mode_seen <= strapSync;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `AXI_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rdByte};
			s_axi_rresp  <= rdHit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	ram_reset_a: assert property (@(posedge clk) $rose(rst_n) |-> onchip_ram_en)
		else $error("RAM enable not set after reset");
	rom_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
		modeValid |-> (romEnable == strapSync[1]))
		else $error("ROM enable disagrees with mode");
	single_chip_a: assert property (@(posedge clk) disable iff (!rst_n)
		(modeValid && strapSync[1:0] == 2'b11) |=> (sharedAddrOut == 16'h0000 && lowAddrOut == 8'h00))
		else $error("Address driven in single-chip mode");
	low_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		(modeValid && !strapSync[1] && $stable(strapSync)) |=> lowAddrOut == 8'hFF)
		else $error("Low address not driven in modes 4 and 5");
	reserved_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
		system_control_reg[6] == 1'b0 && system_control_reg[1] == 1'b0)
		else $error("Reserved control bit set");
	monitor_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 10'h000) |=>
		(s_axi_rvalid && s_axi_rdata[7:3] == 5'h00 && s_axi_rdata[2:0] == $past(strapSync)))
		else $error("Mode monitor read wrong");
	manual_reset_n_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		!system_control_reg[2] |-> !manualResetReq)
		else $error("Manual reset passed while gated");
	bus_width_a: assert property (@(posedge clk) disable iff (!rst_n)
		(modeValid && strapSync[1:0] == 2'b00 && !allArea8 && $stable(strapSync)) |=> bus16)
		else $error("Mode 4 bus not 16 bits");
	advanced_a: assert property (@(posedge clk) advancedMode)
		else $error("Advanced addressing lost");
	addr_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
		(extBusEnable && $stable(extBusEnable) && $stable(addr_output_enable_bits)) |=>
		sharedAddrOut[15:12] == {4{addr_output_enable_bits[3]}})
		else $error("Address enable not followed");

	// Pin role checks
	ext_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
		(modeValid && strapSync[1:0] != 2'b11)
		|-> extBusEnable)
		else $error("External bus off in extended mode");

	bus_narrow_a: assert property (@(posedge clk) disable iff (!rst_n)
		(modeValid && (strapSync[1:0] == 2'b01 || strapSync[1:0] == 2'b10) && anyArea16)
		|=> bus16)
		else $error("Bus not widened by a 16-bit area");

	bus_mode4_a: assert property (@(posedge clk) disable iff (!rst_n)
		(modeValid && strapSync[1:0] == 2'b00 && allArea8)
		|=> !bus16)
		else $error("Mode 4 bus not narrowed");

	single_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
		(modeValid && strapSync[1:0] == 2'b11)
		|=> !bus16)
		else $error("Bus width set in single-chip mode");

	low_port_a: assert property (@(posedge clk) disable iff (!rst_n)
		extBusEnable
		|=> lowPortOut == 8'h00)
		else $error("Low port used as port in extended mode");

	mode6_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		(modeValid && strapSync[1:0] == 2'b10)
		|=> lowAddrOut == $past(lowDdr))
		else $error("Mode 6 low address ignores direction");

	shared_split_a: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1
		|-> (sharedPortOut & sharedAddrOut) == 16'h0000)
		else $error("Shared pin both address and port");

	low_split_a: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1
		|-> (lowPortOut & lowAddrOut) == 8'h00)
		else $error("Low pin both address and port");

	single_port_a: assert property (@(posedge clk) disable iff (!rst_n)
		(modeValid && strapSync[1:0] == 2'b11)
		|=> (sharedPortOut == $past(sharedDdr) && lowPortOut == $past(lowDdr)))
		else $error("Single-chip port not general");

	// Register checks
	ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		(doWrite && wStrb[0] && {awAddr[11:2], 2'b00} == `SYSTEM_CONTROL_OFFSET)
		|=> system_control_reg == ($past(wData[7:0]) & `SYSCTL_WMASK))
		else $error("Control write not stored");

	ctrl_reset_a: assert property (@(posedge clk)
		$rose(rst_n)
		|-> (irqCtrlMode == 2'b00 && !nonmask_irq_edge_sel && !system_control_reg[2]))
		else $error("Control fields not cleared by reset");

	seen_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 10'h000)
		|=> mode_seen == $past(strapSync))
		else $error("Straps not latched on read");

	seen_keep_a: assert property (@(posedge clk)
		(porRst_n && !(s_axi_arvalid && s_axi_arready))
		|=> $stable(mode_seen))
		else $error("Latched straps lost without power-on reset");

	seen_clear_a: assert property (@(posedge clk)
		!porRst_n
		|=> mode_seen == `MODE_SEEN_RESET)
		else $error("Power-on reset did not clear latch");

	// Bus handshake checks; the byte sits in data bits 7:0
	bvalid_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(s_axi_bvalid && !s_axi_bready)
		|=> s_axi_bvalid)
		else $error("Write response dropped early");

	rvalid_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(s_axi_rvalid && !s_axi_rready)
		|=> (s_axi_rvalid && $stable(s_axi_rdata)))
		else $error("Read data dropped early");

	read_upper_a: assert property (@(posedge clk) disable iff (!rst_n)
		s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h000000)
		else $error("Upper read bits not zero");

	wr_block_a: assert property (@(posedge clk) disable iff (!rst_n)
		s_axi_bvalid
		|-> (!s_axi_awready && !s_axi_wready))
		else $error("Write taken while response pending");
endmodule

// >>> pkg/opmode_defines.svh
/*
 Register offsets, field positions, reset values and bus response codes for the operating mode and system control block.
 Assumes inclusion by bare name from design files.
*/
`ifndef OPMODE_DEFINES_SVH
`define OPMODE_DEFINES_SVH
`define MODE_MONITOR_OFFSET 12'h000
`define SYSTEM_CONTROL_OFFSET 12'h004
`define SYSCTL_RESET 8'h01
`define SYSCTL_WMASK 8'hBD
`define SYSCTL_BIT_RSVD7 7
`define SYSCTL_BIT_IRQMODE_HI 5
`define SYSCTL_BIT_IRQMODE_LO 4
`define SYSCTL_BIT_NMIEDGE 3
`define SYSCTL_BIT_MRESEN 2
`define SYSCTL_BIT_RAMEN 0
`define MODE_SEEN_RESET 3'h0
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`define ADDR_SPACE_BITS 24
`endif

// >>> pkg/opmode_pkg.sv
/*
 Types for the operating mode block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package opmode_pkg;
	typedef enum logic [1:0] {
		MODE_EXT_ROMOFF_16,
		MODE_EXT_ROMOFF_8,
		MODE_EXT_ROMON_8,
		MODE_SINGLE_CHIP
	} op_mode_type;
	typedef enum logic [1:0] {
		WR_IDLE,
		WR_RESP
	} wr_state_type;
endpackage

// >>> test/strap_board.sv
/*
 Board model: drives the three mode straps.
 Assumes the bench picks the mode only while rst_n is low.
*/
`timescale 1ns/10ps
module strap_board (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] modeSel,
	output logic            mode_strap_2,
	output logic            mode_strap_1,
	output logic            mode_strap_0
);
	// Straps move only under reset, so the decoder never sees a mid-run change
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{mode_strap_2, mode_strap_1, mode_strap_0} <= {1'b1, modeSel};
		end
	end
endmodule

// >>> test/tb.sv
/*
 Self-checking bench for the operating mode block.
 Assumes the register offsets of opmode_defines.svh and answers within 50 cycles.
*/
`timescale 1ns/10ps
`include "opmode_defines.svh"
module tb;
	logic        clk, rst_n, porRst_n, manual_reset_n, anyArea16, allArea8, s2, s1, s0;
	logic [1:0]  modeSel, bresp, rresp, opMode, irqCtrlMode;
	logic [3:0]  aeBits, wstrb;
	logic [15:0] sharedDdr, sharedAddrOut, sharedPortOut;
	logic [7:0]  lowDdr, lowAddrOut, lowPortOut;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic        modeValid, advancedMode, romEnable, extBusEnable, bus16, nmiEdge, manualResetReq, ramEn;
	logic [1:0]  r;
	int          numErrors, nCompared, cycles;
	strap_board board (.clk(clk), .rst_n(rst_n), .modeSel(modeSel),
		.mode_strap_2(s2), .mode_strap_1(s1), .mode_strap_0(s0));
	operating_mode_system_control DUT (.clk(clk), .rst_n(rst_n), .porRst_n(porRst_n),
		.mode_strap_2(s2), .mode_strap_1(s1), .mode_strap_0(s0), .manual_reset_n(manual_reset_n),
		.addr_output_enable_bits(aeBits), .sharedDdr(sharedDdr), .lowDdr(lowDdr),
		.anyArea16(anyArea16), .allArea8(allArea8), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .modeValid(modeValid),
		.opMode(opMode), .advancedMode(advancedMode), .romEnable(romEnable), .extBusEnable(extBusEnable),
		.bus16(bus16), .sharedAddrOut(sharedAddrOut), .sharedPortOut(sharedPortOut),
		.lowAddrOut(lowAddrOut), .lowPortOut(lowPortOut), .irqCtrlMode(irqCtrlMode),
		.nonmask_irq_edge_sel(nmiEdge), .manualResetReq(manualResetReq), .onchip_ram_en(ramEn));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task automatic printVerdict();
		$display("compared %0d mismatches %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Ceiling far above the hundred-odd cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			printVerdict();
		end
	end
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		nCompared++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			numErrors++;
		end
	endtask
	task automatic doReset(input logic [1:0] m, input logic por);
		@(posedge clk);
		rst_n <= 1'b0;
		porRst_n <= !por;
		modeSel <= m;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		porRst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task automatic axiWrite(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		logic ta, tw, dA, dW, t;
		n = 0;
		dA = 0;
		dW = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(dA && dW) && n < 50) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge clk);
			n++;
			if (ta) begin
				awvalid <= 1'b0;
				dA = 1;
			end
			if (tw) begin
				wvalid <= 1'b0;
				dW = 1;
			end
		end
		do begin
			@(negedge clk);
			t = bvalid;
			rs = bresp;
			@(posedge clk);
			n++;
		end while (t !== 1'b1 && n < 50);
		bready <= 1'b0;
		if (n >= 50) check("writeAnswer", 1, 0);
	endtask
	task automatic axiRead(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		logic t;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			t = arready;
			@(posedge clk);
			n++;
		end while (t !== 1'b1 && n < 50);
		arvalid <= 1'b0;
		do begin
			@(negedge clk);
			t = rvalid;
			v = rdata;
			rs = rresp;
			@(posedge clk);
			n++;
		end while (t !== 1'b1 && n < 50);
		rready <= 1'b0;
		if (n >= 50) check("readAnswer", 1, 0);
	endtask
	task automatic widthChange(input logic [1:0] m);
		@(posedge clk);
		allArea8 <= (m == 2'h0);
		anyArea16 <= (m != 2'h0);
		repeat (4) @(posedge clk);
		check("bus16Changed", m != 2'h0, bus16);
		allArea8 <= 1'b0;
		anyArea16 <= 1'b0;
	endtask
	task automatic checkMode(input logic [1:0] m);
		doReset(m, 1'b1);
		@(negedge clk);
		check("modeValid", 1, modeValid);
		check("opMode", m, opMode);
		check("advancedMode", 1, advancedMode);
		check("romEnable", m[1], romEnable);
		check("extBusEnable", m != 2'h3, extBusEnable);
		axiRead(`MODE_MONITOR_OFFSET, d, r);
		check("monitor", {29'h0, 1'b1, m}, d);
		if (m != 2'h3) check("bus16", m == 2'h0, bus16);
		if (m < 2'h2) check("lowAddr", 32'hFF, lowAddrOut);
		if (m == 2'h2) check("lowAddr6", 32'hA5, lowAddrOut);
		if (m == 2'h3) check("noAddr", 0, {sharedAddrOut, lowAddrOut});
		if (m < 2'h3) widthChange(m);
	endtask
	task automatic controlReg();
		doReset(2'h0, 1'b1);
		axiRead(`SYSTEM_CONTROL_OFFSET, d, r);
		check("ctrlReset", 32'h01, d);
		check("fieldsReset", 32'h1, {irqCtrlMode, nmiEdge, ramEn});
		axiWrite(`SYSTEM_CONTROL_OFFSET, 32'h6E, r);
		axiRead(`SYSTEM_CONTROL_OFFSET, d, r);
		check("ctrlWritten", 32'h2C, d);
		check("fieldsSet", 32'hA, {irqCtrlMode, nmiEdge, ramEn});
		manual_reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		check("mresGated", 1, manualResetReq);
		axiWrite(`SYSTEM_CONTROL_OFFSET, 32'h00, r);
		repeat (2) @(posedge clk);
		check("mresBlocked", 0, manualResetReq);
		check("fieldsClear", 0, {irqCtrlMode, nmiEdge, ramEn});
		manual_reset_n <= 1'b1;
		doReset(2'h0, 1'b0);
		axiRead(`SYSTEM_CONTROL_OFFSET, d, r);
		check("ramBack", 32'h01, d);
		axiWrite(`MODE_MONITOR_OFFSET, 32'hFF, r);
		check("monWrResp", `AXI_RESP_OKAY, r);
		axiRead(`MODE_MONITOR_OFFSET, d, r);
		check("monKept", 32'h04, d);
		axiRead(12'h008, d, r);
		check("rdUnmapped", `AXI_RESP_SLVERR, r);
		axiWrite(12'h00C, 32'h0, r);
		check("wrUnmapped", `AXI_RESP_SLVERR, r);
	endtask
	initial begin
		{rst_n, porRst_n, anyArea16, allArea8, modeSel, aeBits, sharedDdr} = 0;
		{awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = 0;
		manual_reset_n = 1'b1;
		lowDdr = 8'hA5;
		numErrors = 0;
		nCompared = 0;
		cycles = 0;
		for (int m = 0; m < 4; m++) checkMode(m[1:0]);
		controlReg();
		printVerdict();
	end
endmodule
